// file: logic/emp_pkg.sv
// Package for the external memory strobes and Port 0 block.
// Assumes a single clock domain and the plain register port of the block.
package emp_pkg;

  // Register indices on the plain register port.
  localparam int EMP_ADDR_W = 4;
  localparam logic [3:0] REG_P0_MODE = 4'h0;
  localparam logic [3:0] REG_P0_DATA = 4'h1;
  localparam logic [3:0] REG_P3_MODE = 4'h2;
  localparam logic [3:0] REG_ADDR_LO = 4'h3;
  localparam logic [3:0] REG_ADDR_HI = 4'h4;
  localparam logic [3:0] REG_WDATA = 4'h5;
  localparam logic [3:0] REG_COMMAND = 4'h6;
  localparam logic [3:0] REG_STATUS = 4'h7;
  localparam logic [3:0] REG_RDATA = 4'h8;

  // Port 0 nibble modes, two bits per nibble in the Port 0 mode register.
  localparam logic [1:0] NIB_OUTPUT = 2'h0;
  localparam logic [1:0] NIB_INPUT = 2'h1;
  localparam logic [1:0] NIB_ADDRESS = 2'h2;
  localparam int P0M_LOW_LSB = 0;
  localparam int P0M_HIGH_LSB = 2;
  localparam logic [3:0] P0M_RESET = 4'h5;

  // Port 3 mode register fields.
  localparam int P3M_HANDSHAKE = 2;
  localparam int P3M_FLOAT_LO = 3;
  localparam int P3M_FLOAT_HI = 4;
  localparam logic [7:0] P3M_RESET = 8'h00;

  // Command register fields.
  localparam int CMD_WRITE = 0;
  localparam int CMD_CODE = 1;

  // Status register fields.
  localparam int ST_BUSY = 0;
  localparam int ST_ROMLESS = 1;
  localparam int ST_INTERNAL = 2;
  localparam int ST_HS_PEND = 3;

  // Strobe timing, in cycles of the 200 MHz reference clock.
  localparam int CLK_PERIOD_PS = 5000;
  localparam int DS_WIDTH_PS = 10000;
  localparam int DS_CYCLES_RAW = (DS_WIDTH_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int DS_CYCLES = (DS_CYCLES_RAW < 1) ? 1 : DS_CYCLES_RAW;

  typedef enum logic [2:0] {
    EMP_IDLE,
    EMP_ADDR,
    EMP_HOLD,
    EMP_DATA,
    EMP_RECOVER
  } emp_state_t;

endpackage

// file: logic/emp_port0_top.sv
// External memory strobe sequencer with the configurable Port 0 and its handshake.
// Assumes synchronous pin inputs, one 200 MHz clock and a plain register port.
//
// Overview of operation
// R01: The data strobe goes low exactly once per external transfer.
// R02: Memory presents read data before the data strobe rises again.
// R03: Write data is driven on the bus no later than the data strobe falls.
// R04: The address strobe pulses once at the start of every machine cycle; the code pulses it only on external cycles, not for internal ROM fetches.
// R05: Address on Ports 0 and 1 is valid when the address strobe rises.
// R06: Read/write line is low during writes to external memory, high otherwise.
// R07: Strap low forces every code fetch external; open or high uses internal ROM.
// R08: Software sets Port 0 as nibble I/O or address output, push-pull drive.
// R09: Nibble I/O use of Port 0 is chosen by writing the Port 0 mode register.
// R10: In handshake mode Port 3 lines P32 and P35 carry valid strobe and ready.
// R11: Handshake direction follows the upper nibble; lower nibble must match.
// R12: Port 0 carries A11-A8 on the low nibble or A15-A8 on both nibbles.
// R13: With 12-bit addressing the upper nibble stays usable as ordinary I/O.
// R14: After hardware reset every Port 0 line is an input.
// R15: Port 3 mode bits D4 and D3 float Port 0 address, Port 1 and strobes.
// R16: A fitted Port 0 pull-up is off for each bit configured as output.
// R17: Port 1 carries A7-A0 then D7-D0, framed by address and data strobes.
// R18: Each access runs address strobe, release, data strobe, release, then ends.
module emp_port0_top
  import emp_pkg::*;
#(
  parameter int ROM_BYTES = 16384,
  parameter logic [7:0] PULLUP_FITTED = 8'hff
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [EMP_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic rom_disable_strap_n,
  input wire logic [7:0] port0_in,
  output logic [7:0] port0_out,
  output logic [7:0] port0_oe,
  output logic [7:0] port0_pullup_en,
  input wire logic [7:0] port1_in,
  output logic [7:0] port1_out,
  output logic [7:0] port1_oe,
  output logic address_strobe_n,
  output logic address_strobe_oe,
  output logic transfer_strobe_n,
  output logic transfer_strobe_oe,
  output logic read_write,
  output logic read_write_oe,
  input wire logic hs_p32_in,
  output logic hs_p35_out
);

  // A limit beyond the 64K space has no meaning for a 16-bit fetch address.
  if (ROM_BYTES < 1 || ROM_BYTES > 65536) begin : g_rom_bytes_check
    $error("ROM_BYTES must lie between 1 and 65536.");
  end
  // The strobe width counter is three bits wide.
  if (DS_CYCLES < 1 || DS_CYCLES > 8) begin : g_ds_cycles_check
    $error("DS_CYCLES must lie between 1 and 8.");
  end

  localparam logic [16:0] ROM_LIMIT = 17'(ROM_BYTES);
  localparam logic [2:0] DS_LAST = 3'(DS_CYCLES - 1);

  logic rst_meta_n;
  logic rst_sync_n;
  logic strap_taken;
  logic romless;
  logic [3:0] p0_mode;
  logic [7:0] p0_data;
  logic [7:0] p3_mode;
  logic [7:0] ext_addr_lo;
  logic [7:0] ext_addr_hi;
  logic [7:0] ext_wdata;
  logic [7:0] ext_rdata;
  logic cyc_write;
  logic served_internal;
  emp_state_t state;
  logic [2:0] ds_count;
  logic hs_pending;
  logic hs_data_age;
  logic hs_strobe_prev;
  logic [7:0] hs_latched;

  logic [1:0] mode_lo;
  logic [1:0] mode_hi;
  logic float_bus;
  logic handshake_on;
  logic upper_is_output;
  logic start_cmd;
  logic fetch_internal;
  logic hs_dir_change;
  logic [7:0] next_p0_out;
  logic [7:0] next_p0_oe;

  assign mode_lo = p0_mode[P0M_LOW_LSB +: 2];
  assign mode_hi = p0_mode[P0M_HIGH_LSB +: 2];
  assign float_bus = p3_mode[P3M_FLOAT_HI] & p3_mode[P3M_FLOAT_LO]; // R15
  assign handshake_on = p3_mode[P3M_HANDSHAKE];
  assign upper_is_output = (mode_hi == NIB_OUTPUT); // R11
  assign start_cmd = reg_wr && reg_addr == REG_COMMAND && state == EMP_IDLE;
  // Code below the ROM limit stays on chip unless the strap was caught low.
  assign fetch_internal = reg_wdata[CMD_CODE] && !reg_wdata[CMD_WRITE] && !romless
    && {1'b0, ext_addr_hi, ext_addr_lo} < ROM_LIMIT; // R07
  // Software moving the upper nibble, and with it the handshake, to the other direction.
  assign hs_dir_change = reg_wr && reg_addr == REG_P0_MODE
    && ((reg_wdata[P0M_HIGH_LSB +: 2] == NIB_OUTPUT) != upper_is_output); // R11

  // The reset pin is asynchronous; its release is retimed so all flops leave reset together.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // The strap is sampled once after reset release, never under the reset itself.
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      strap_taken <= 1'b0;
      romless <= 1'b0;
    end else if (!strap_taken) begin
      strap_taken <= 1'b1;
      romless <= !rom_disable_strap_n; // R07
    end
  end

  // Configuration registers written by software.
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      p0_mode <= P0M_RESET; // R14
      p3_mode <= P3M_RESET;
      p0_data <= 8'h00;
      ext_addr_lo <= 8'h00;
      ext_addr_hi <= 8'h00;
      ext_wdata <= 8'h00;
    end else if (reg_wr) begin
      unique case (reg_addr)
        REG_P0_MODE: p0_mode <= reg_wdata[3:0]; // R09
        REG_P3_MODE: p3_mode <= reg_wdata;
        REG_P0_DATA: p0_data <= reg_wdata;
        REG_ADDR_LO: ext_addr_lo <= reg_wdata;
        REG_ADDR_HI: ext_addr_hi <= reg_wdata;
        REG_WDATA: ext_wdata <= reg_wdata;
        default: ;
      endcase
    end
  end

  // External machine cycle: address phase, strobe release, data phase, recovery.
  // Address registers are not locked during a cycle; software waits for busy to clear.
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state <= EMP_IDLE;
      ds_count <= 3'h0;
      cyc_write <= 1'b0;
      served_internal <= 1'b0;
      ext_rdata <= 8'h00;
      address_strobe_n <= 1'b1;
      transfer_strobe_n <= 1'b1;
      read_write <= 1'b1;
      port1_out <= 8'h00;
      port1_oe <= 8'h00;
    end else begin
      unique case (state)
        EMP_IDLE: begin
          if (start_cmd && fetch_internal) begin
            served_internal <= 1'b1; // R07
          end else if (start_cmd) begin
            served_internal <= 1'b0;
            cyc_write <= reg_wdata[CMD_WRITE];
            state <= EMP_ADDR;
            address_strobe_n <= 1'b0; // R04
            read_write <= !reg_wdata[CMD_WRITE]; // R06
            port1_out <= ext_addr_lo; // R17
            port1_oe <= {8{!float_bus}}; // R15
          end
        end
        EMP_ADDR: begin
          state <= EMP_HOLD;
          address_strobe_n <= 1'b1; // R05
        end
        EMP_HOLD: begin
          state <= EMP_DATA;
          ds_count <= DS_LAST;
          transfer_strobe_n <= 1'b0; // R01
          port1_out <= ext_wdata; // R03
          port1_oe <= {8{cyc_write && !float_bus}}; // R03
        end
        EMP_DATA: begin
          if (ds_count == 3'h0) begin
            state <= EMP_RECOVER;
            transfer_strobe_n <= 1'b1; // R18
            // The last strobe edge is the latest point at which memory must drive its data.
            if (!cyc_write) begin
              ext_rdata <= port1_in; // R02
            end
          end else begin
            ds_count <= ds_count - 3'h1;
          end
        end
        EMP_RECOVER: begin
          state <= EMP_IDLE;
          read_write <= 1'b1; // R06
          port1_oe <= 8'h00;
        end
      endcase
      // Floating mid-cycle releases Port 1 at once, together with the strobes.
      if (float_bus) begin
        port1_oe <= 8'h00; // R15
      end
    end
  end

  // Strobe and control drivers float with the bus.
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      address_strobe_oe <= 1'b1;
      transfer_strobe_oe <= 1'b1;
      read_write_oe <= 1'b1;
    end else begin
      address_strobe_oe <= !float_bus; // R15
      transfer_strobe_oe <= !float_bus;
      read_write_oe <= !float_bus;
    end
  end

  // Port 0 handshake on P32 and P35. Input direction: P32 is the valid strobe in,
  // P35 the ready out. Output direction: P35 is the valid strobe out, P32 the ready in.
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      hs_pending <= 1'b0;
      hs_data_age <= 1'b0;
      hs_strobe_prev <= 1'b1;
      hs_latched <= 8'h00;
      hs_p35_out <= 1'b1;
    end else begin
      hs_strobe_prev <= hs_p32_in;
      if (!handshake_on || hs_dir_change) begin
        // A direction change drops a byte in flight rather than finish it the wrong way.
        hs_pending <= 1'b0;
        hs_data_age <= 1'b0;
        hs_p35_out <= 1'b1;
      end else if (upper_is_output) begin
        if (reg_wr && reg_addr == REG_P0_DATA) begin
          // A new byte restarts the strobe so it is never taken under an old ready.
          hs_pending <= 1'b1;
          hs_data_age <= 1'b0;
          hs_p35_out <= 1'b1;
        end else if (hs_pending && hs_p35_out && !hs_data_age) begin
          // The byte reaches the pins one cycle after the write; the strobe waits for it.
          hs_data_age <= 1'b1;
        end else if (hs_pending && hs_p35_out) begin
          hs_p35_out <= 1'b0; // R10
        end else if (hs_pending && !hs_p32_in) begin
          hs_pending <= 1'b0;
          hs_p35_out <= 1'b1; // R10
        end
      end else begin
        if (hs_strobe_prev && !hs_p32_in && !hs_pending) begin
          hs_latched <= port0_in; // R10
          hs_pending <= 1'b1;
          hs_p35_out <= 1'b0;
        end else if (hs_pending && reg_rd && reg_addr == REG_P0_DATA) begin
          hs_pending <= 1'b0;
          hs_p35_out <= 1'b1;
        end
      end
    end
  end

  // Port 0 pin drive per nibble; an address nibble floats with the bus.
  always_comb begin
    next_p0_out = p0_data;
    next_p0_oe = 8'h00;
    unique case (mode_lo)
      NIB_OUTPUT: next_p0_oe[3:0] = 4'hf; // R08
      NIB_ADDRESS: begin
        next_p0_out[3:0] = ext_addr_hi[3:0]; // R12
        next_p0_oe[3:0] = {4{!float_bus}}; // R15
      end
      default: next_p0_oe[3:0] = 4'h0;
    endcase
    unique case (mode_hi)
      NIB_OUTPUT: next_p0_oe[7:4] = 4'hf; // R13
      NIB_ADDRESS: begin
        next_p0_out[7:4] = ext_addr_hi[7:4]; // R12
        next_p0_oe[7:4] = {4{!float_bus}};
      end
      default: next_p0_oe[7:4] = 4'h0;
    endcase
  end

  // Pull-ups follow the next drive, so a pin never pulls against its own output.
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      port0_out <= 8'h00;
      port0_oe <= 8'h00; // R14
      port0_pullup_en <= PULLUP_FITTED;
    end else begin
      port0_out <= next_p0_out; // R08
      port0_oe <= next_p0_oe;
      port0_pullup_en <= PULLUP_FITTED & ~next_p0_oe; // R16
    end
  end

  // Read data stand in the cycle after the read strobe; unmapped reads return zero.
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        REG_P0_MODE: reg_rdata <= {4'h0, p0_mode};
        REG_P0_DATA: reg_rdata <= (handshake_on && !upper_is_output) ? hs_latched : port0_in;
        REG_P3_MODE: reg_rdata <= p3_mode;
        REG_ADDR_LO: reg_rdata <= ext_addr_lo;
        REG_ADDR_HI: reg_rdata <= ext_addr_hi;
        REG_WDATA: reg_rdata <= ext_wdata;
        REG_STATUS: begin
          reg_rdata <= 8'h00;
          reg_rdata[ST_BUSY] <= (state != EMP_IDLE);
          reg_rdata[ST_ROMLESS] <= romless;
          reg_rdata[ST_INTERNAL] <= served_internal;
          reg_rdata[ST_HS_PEND] <= hs_pending;
        end
        REG_RDATA: reg_rdata <= ext_rdata;
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule

// file: tb/emp_port0_props.sv
// Checker for the external memory strobes and Port 0 pins.
// Assumes it is bound to the top module and sees only its ports.
module emp_port0_props (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic address_strobe_n,
  input wire logic transfer_strobe_n,
  input wire logic read_write,
  input wire logic [7:0] port1_out,
  input wire logic [7:0] port1_oe,
  input wire logic [7:0] port0_oe,
  input wire logic [7:0] port0_pullup_en,
  input wire logic hs_p35_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  AST_AS_PULSE: assert property ($fell(address_strobe_n) |=> address_strobe_n)
    else $error("address strobe low too long");
  AST_AS_THEN_DS: assert property ($fell(address_strobe_n) |-> ##2 $fell(transfer_strobe_n))
    else $error("data strobe not two cycles after address strobe");
  AST_DS_WIDTH: assert property ($fell(transfer_strobe_n) |=> !transfer_strobe_n ##1 transfer_strobe_n)
    else $error("data strobe width wrong");
  AST_DS_NEEDS_AS: assert property ($fell(transfer_strobe_n) |-> $past(address_strobe_n, 2) == 1'b0)
    else $error("data strobe without address strobe");
  AST_ADDR_HOLD: assert property ($fell(address_strobe_n) |-> port1_oe == 8'hff ##1 $stable(port1_out))
    else $error("address not held through strobe");
  AST_WR_DATA: assert property ($fell(transfer_strobe_n) && !read_write |-> port1_oe == 8'hff ##1 $stable(port1_out))
    else $error("write data not valid at data strobe");
  AST_RW_WRITE: assert property ($fell(read_write) |-> $fell(address_strobe_n) ##1 !read_write [*4] ##1 read_write)
    else $error("read write line wrong in write cycle");
  AST_RD_RELEASE: assert property (!transfer_strobe_n && read_write |-> port1_oe == 8'h00)
    else $error("port 1 driven during read");
  AST_PULLUP_OFF: assert property ((port0_pullup_en & port0_oe) == 8'h00)
    else $error("pull-up on for an output bit");
  COV_WRITE: cover property ($fell(read_write));
  COV_READ: cover property ($fell(transfer_strobe_n) && read_write);
  COV_HANDSHAKE: cover property ($fell(hs_p35_out));
endmodule

bind emp_port0_top emp_port0_props u_props (.ref_clk(ref_clk), .rst_n(rst_n),
  .address_strobe_n(address_strobe_n), .transfer_strobe_n(transfer_strobe_n),
  .read_write(read_write), .port1_out(port1_out), .port1_oe(port1_oe), .port0_oe(port0_oe),
  .port0_pullup_en(port0_pullup_en), .hs_p35_out(hs_p35_out));

// file: tb/emp_mem_model.sv
// Behavioural external memory on the multiplexed Port 1 bus.
// Assumes the strobes and Port 0/1 drive come straight from the device pins.
module emp_mem_model (
  input wire logic address_strobe_n,
  input wire logic transfer_strobe_n,
  input wire logic read_write,
  input wire logic [7:0] port0_out,
  input wire logic [7:0] port1_out,
  output logic [7:0] port1_in,
  output logic [15:0] addr,
  output int xfers
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  logic [7:0] last = 8'h00;
  initial addr = 16'h0000;
  initial xfers = 0;
  always @(posedge address_strobe_n) addr <= {port0_out, port1_out};
  always @(negedge transfer_strobe_n) xfers <= xfers + 1;
  always @(posedge transfer_strobe_n) begin
    if (!read_write) mem[addr[7:0]] <= port1_out;
    else last <= mem[addr[7:0]];
  end
  // Off a read the bus shows the inverse of the last byte, so a late sample never matches.
  always_comb begin
    if (!transfer_strobe_n && read_write) port1_in = mem[addr[7:0]];
    else port1_in = ~last;
  end
endmodule

// file: tb/emp_port0_top_tb.sv
// Bench for the external memory strobes and Port 0 block.
// Assumes the memory model on Port 1 and the checker bound to the top.
module emp_port0_top_tb;
  import emp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic rom_disable_strap_n = 1'b1, hs_p32_in = 1'b1;
  logic [EMP_ADDR_W-1:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, port0_in = 8'h00, v;
  logic [7:0] reg_rdata, port0_out, port0_oe, port0_pullup_en, port1_in, port1_out, port1_oe;
  logic address_strobe_n, address_strobe_oe, transfer_strobe_n, transfer_strobe_oe;
  logic read_write, read_write_oe, hs_p35_out;
  logic [15:0] mem_addr;
  int xfers, bad_count = 0, checked = 0;
  always #2.5 ref_clk = ~ref_clk;
  emp_port0_top u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rom_disable_strap_n(rom_disable_strap_n), .port0_in(port0_in), .port0_out(port0_out),
    .port0_oe(port0_oe), .port0_pullup_en(port0_pullup_en), .port1_in(port1_in),
    .port1_out(port1_out), .port1_oe(port1_oe), .address_strobe_n(address_strobe_n),
    .address_strobe_oe(address_strobe_oe), .transfer_strobe_n(transfer_strobe_n),
    .transfer_strobe_oe(transfer_strobe_oe), .read_write(read_write),
    .read_write_oe(read_write_oe), .hs_p32_in(hs_p32_in), .hs_p35_out(hs_p35_out));
  emp_mem_model u_mem (.address_strobe_n(address_strobe_n),
    .transfer_strobe_n(transfer_strobe_n), .read_write(read_write), .port0_out(port0_out),
    .port1_out(port1_out), .port1_in(port1_in), .addr(mem_addr), .xfers(xfers));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // A second command inside the busy window must be dropped, so each call is at most one transfer.
  task automatic ext(input logic [7:0] hi, lo, wd, cmd);
    logic [7:0] s;
    wr(REG_ADDR_HI, hi);
    wr(REG_ADDR_LO, lo);
    wr(REG_WDATA, wd);
    wr(REG_COMMAND, cmd);
    wr(REG_COMMAND, cmd);
    for (int i = 0; i < 20; i++) begin
      rd(REG_STATUS, s);
      if (s[ST_BUSY] === 1'b0) return;
    end
    check("busy", 1'b1, 1'b0);
    end_of_test();
  endtask
  task automatic do_reset(input logic strap);
    rst_n <= 1'b0;
    rom_disable_strap_n <= strap;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
  endtask
  initial begin
    do_reset(1'b1);
    check("p0 oe", port0_oe, 8'h00);
    check("pullups", port0_pullup_en, 8'hff);
    check("idle pins", {address_strobe_n, transfer_strobe_n, read_write}, 3'h7);
    ext(8'h12, 8'h34, 8'h00, 8'h02);
    rd(REG_STATUS, v);
    check("internal", v[ST_INTERNAL], 1'b1);
    check("romless", v[ST_ROMLESS], 1'b0);
    check("xfers", xfers, 0);
    wr(REG_P0_MODE, 8'h0a);
    ext(8'hc3, 8'h5a, 8'h96, 8'h01);
    check("xfers", xfers, 1);
    check("address", mem_addr, 16'hc35a);
    check("stored", u_mem.mem[8'h5a], 8'h96);
    ext(8'hc3, 8'h5a, 8'h00, 8'h00);
    rd(REG_RDATA, v);
    check("read data", v, 8'h96);
    repeat (2) @(negedge ref_clk);
    check("rdata cleared", reg_rdata, 8'h00);
    wr(REG_P0_MODE, 8'h02);
    wr(REG_P0_DATA, 8'h70);
    ext(8'h3b, 8'h10, 8'h44, 8'h01);
    @(negedge ref_clk);
    check("upper io", port0_out[7:4], 4'h7);
    check("low address", mem_addr[11:8], 4'hb);
    check("p0 oe", port0_oe, 8'hff);
    wr(REG_P0_MODE, 8'h01);
    repeat (2) @(negedge ref_clk);
    check("nibble oe", port0_oe, 8'hf0);
    check("pullups", port0_pullup_en, 8'h0f);
    wr(REG_P0_MODE, 8'h0a);
    wr(REG_P3_MODE, 8'h18);
    repeat (2) @(negedge ref_clk);
    check("float", {address_strobe_oe, transfer_strobe_oe, read_write_oe, port1_oe}, 11'h0);
    check("float p0", port0_oe, 8'h00);
    wr(REG_P3_MODE, 8'h04);
    wr(REG_P0_MODE, 8'h05);
    @(posedge ref_clk);
    port0_in <= 8'h3c;
    hs_p32_in <= 1'b0;
    repeat (2) @(negedge ref_clk);
    check("ready low", hs_p35_out, 1'b0);
    rd(REG_STATUS, v);
    check("hs pending", v[ST_HS_PEND], 1'b1);
    rd(REG_P0_DATA, v);
    check("hs data", v, 8'h3c);
    repeat (2) @(negedge ref_clk);
    check("ready high", hs_p35_out, 1'b1);
    @(posedge ref_clk);
    hs_p32_in <= 1'b1;
    wr(REG_P0_MODE, 8'h00);
    wr(REG_P0_DATA, 8'ha5);
    repeat (2) @(negedge ref_clk);
    check("out data", port0_out, 8'ha5);
    check("valid waits", hs_p35_out, 1'b1);
    @(negedge ref_clk);
    check("valid low", hs_p35_out, 1'b0);
    @(posedge ref_clk);
    hs_p32_in <= 1'b0;
    repeat (2) @(negedge ref_clk);
    check("valid high", hs_p35_out, 1'b1);
    rd(4'hf, v);
    check("unmapped", v, 8'h00);
    do_reset(1'b0);
    check("p0 oe", port0_oe, 8'h00);
    ext(8'h12, 8'h34, 8'h00, 8'h02);
    check("xfers", xfers, 4);
    rd(REG_STATUS, v);
    check("romless", v[ST_ROMLESS], 1'b1);
    check("external", v[ST_INTERNAL], 1'b0);
    end_of_test();
  end
endmodule
